// file: rtl/store_limiter_pkg.sv
// Package with constants and types of the store limiter and limit tag logic.
package store_limiter_pkg;
  localparam int DATA_W         = 40;
  localparam int NUM_DREGS      = 16;
  localparam int DREG_IDX_W     = 4;
  localparam int LIMITERS_PER_BUS = 4;
  localparam int SLOT_W         = 16;
  localparam int BUS_W          = 64;
  localparam int SCALE_LOW_POS  = 4;
  localparam int SCALE_HIGH_POS = 5;
  localparam int SAT_MODE_POS   = 2;
  localparam int CLK_PERIOD_NS  = 50;

  localparam logic [15:0] WORD_POS_MAX = 16'h7fff;
  localparam logic [15:0] WORD_NEG_MAX = 16'h8000;
  localparam logic [31:0] LONG_POS_MAX = 32'h7fffffff;
  localparam logic [31:0] LONG_NEG_MAX = 32'h80000000;
  localparam logic [4:0]  RND_POS_NONE = 5'h10;
  localparam logic [4:0]  RND_POS_DOWN = 5'h11;
  localparam logic [4:0]  RND_POS_UP   = 5'h0f;

  localparam logic [2:0] APB_OFS_STATUS  = 3'h0;
  localparam logic [2:0] APB_OFS_TAGS    = 3'h1;
  localparam logic [2:0] APB_OFS_STORES  = 3'h2;
  localparam logic [2:0] APB_OFS_RNDPOS  = 3'h3;
  localparam logic [31:0] STATUS_RESET   = 32'h00000000;

  typedef enum logic [1:0] {
    SCALE_NONE = 2'b00,
    SCALE_DOWN = 2'b01,
    SCALE_UP   = 2'b10,
    SCALE_RSVD = 2'b11
  } scale_mode_type;

  typedef enum logic [1:0] {
    TAG_KEEP    = 2'b00,
    TAG_CLEAR   = 2'b01,
    TAG_CALC    = 2'b10,
    TAG_SPECIAL = 2'b11
  } tag_class_type;

  typedef enum logic [2:0] {
    ST_NONE   = 3'b000,
    ST_PLAIN  = 3'b001,
    ST_FRAC   = 3'b010,
    ST_TWO_F  = 3'b011,
    ST_FOUR_F = 3'b100,
    ST_LONG   = 3'b101
  } store_kind_type;

  typedef struct packed {
    logic                  valid;
    logic [DREG_IDX_W-1:0] dest;
    logic [DATA_W-1:0]     value;
    tag_class_type         tag_class;
    logic                  restore;
    logic                  restore_tag;
  } reg_write_type;

  typedef struct packed {
    store_kind_type        kind;
    logic [DREG_IDX_W-1:0] src0;
    logic [DREG_IDX_W-1:0] src1;
  } store_req_type;
endpackage : store_limiter_pkg

// file: rtl/store_limiter_tag_logic.sv
// Limit tags, store shifters and limiters of the data arithmetic unit.
//
// Functional notes
// RULE1: Limit only the four limited-store move kinds.
// RULE2: Tag set replaces stored value with saturation.
// RULE3: Registers never shifted or limited by stores.
// RULE4: Tag set when defining extension bits differ.
// RULE5: Saturable arithmetic instructions compute the tag.
// RULE6: Saturation mode clears tag except special six.
// RULE7: Saturation mode forces no-scaling tag bits.
// RULE8: Listed instructions and moves always clear tag.
// RULE9: Stack restore move loads extension and tag.
// RULE10: Four 16-bit limiters per bus, pairable; the code limits two per bus, in bits 31:0.
// RULE11: Substitute follows sign of 40-bit source.
// RULE12: Saturation mode skips store scaling, keeps limiting.
// RULE13: Saturation mode ignores scaling; special six unsaturated.
// RULE14: Rounding follows scaling only without saturation.
// RULE15: Fractional point after high portion MSB.
// RULE16: Signed fractional extremes are 8000 and 7FFF.
// RULE17: Signed integer extremes in two's complement.
// RULE18: Unsigned integer ranges from zero upward.
// RULE19: Scaling bits at status positions 4 and 5.
// RULE20: One tag flop per data register.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module store_limiter_tag_logic #(
  parameter int NUM_REGS = store_limiter_pkg::NUM_DREGS
) (
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [11:0]                          paddr,
  input  wire logic [31:0]                          pwdata,
  output logic      [31:0]                          prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire store_limiter_pkg::reg_write_type     reg_write,
  input  wire store_limiter_pkg::store_req_type     store_req,
  output logic      [store_limiter_pkg::BUS_W-1:0]  data_bus_a,
  output logic      [store_limiter_pkg::BUS_W-1:0]  data_bus_b,
  output logic                                      bus_valid,
  output logic      [store_limiter_pkg::DATA_W-1:0] reg_read_value,
  output logic                                      limit_tag_bit,
  output logic      [4:0]                           round_position
);
  import store_limiter_pkg::*;

  logic [DATA_W-1:0]   data_register_n [NUM_REGS];
  logic [NUM_REGS-1:0] limit_tags_r;
  logic [31:0]         core_status_register;
  logic [15:0]         store_count_r;
  logic                tag_nxt;
  logic                arith_saturation_mode;
  logic                scale_mode_low_bit;
  logic                scale_mode_high_bit;
  scale_mode_type      scale_eff;
  scale_mode_type      store_scale;
  logic [DATA_W-1:0]   src0_val;
  logic [DATA_W-1:0]   src1_val;
  logic [DATA_W-1:0]   src0_scaled;
  logic [DATA_W-1:0]   src1_scaled;
  logic                src0_tag;
  logic                src1_tag;
  logic [BUS_W-1:0]    bus_a_nxt;
  logic [BUS_W-1:0]    bus_b_nxt;
  logic [4:0]          rnd_nxt;
  logic                apb_access;

  assign arith_saturation_mode = core_status_register[SAT_MODE_POS];
  assign scale_mode_low_bit    = core_status_register[SCALE_LOW_POS];  // see RULE19
  assign scale_mode_high_bit   = core_status_register[SCALE_HIGH_POS]; // see RULE19

  // Saturation mode forces the no-scaling view for tags.
  always_comb begin
    scale_eff = scale_mode_type'({scale_mode_high_bit, scale_mode_low_bit});
    if (arith_saturation_mode) begin
      scale_eff = SCALE_NONE; // see RULE7 see RULE13
    end
  end

  function automatic logic calc_tag(input logic [DATA_W-1:0] v, input scale_mode_type s);
    logic r;
    r = 1'b0;
    unique case (s)
      SCALE_DOWN: r = !((&v[39:32]) || !(|v[39:32]));
      SCALE_UP:   r = !((&v[39:30]) || !(|v[39:30]));
      default:    r = !((&v[39:31]) || !(|v[39:31]));
    endcase
    return r; // see RULE4
  endfunction : calc_tag

  // Tag for the current register write.
  always_comb begin
    tag_nxt = 1'b0;
    if (reg_write.restore) begin
      tag_nxt = reg_write.restore_tag; // see RULE9
    end else begin
      unique case (reg_write.tag_class)
        TAG_CALC:    tag_nxt = arith_saturation_mode ? 1'b0 :
                               calc_tag(reg_write.value, scale_eff); // see RULE5 see RULE6
        TAG_SPECIAL: tag_nxt = calc_tag(reg_write.value, scale_eff); // see RULE6
        TAG_CLEAR:   tag_nxt = 1'b0; // see RULE8
        TAG_KEEP:    tag_nxt = 1'b0;
      endcase
    end
  end

  // Data registers are written only through the reg_write port (results, moves, restores), never by stores.
  always_ff @(posedge pclk) begin
    if (reg_write.valid) begin
      data_register_n[reg_write.dest] <= reg_write.value; // see RULE3 see RULE15
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_tags_r <= '0;
    end else if (reg_write.valid && reg_write.tag_class != TAG_KEEP) begin
      limit_tags_r[reg_write.dest] <= tag_nxt; // see RULE20
    end else if (reg_write.valid && reg_write.restore) begin
      limit_tags_r[reg_write.dest] <= tag_nxt; // see RULE9
    end
  end

  // Store path: scaling, then limiting.
  assign src0_val = data_register_n[store_req.src0];
  assign src1_val = data_register_n[store_req.src1];
  assign src0_tag = limit_tags_r[store_req.src0];
  assign src1_tag = limit_tags_r[store_req.src1];

  always_comb begin
    store_scale = scale_mode_type'({scale_mode_high_bit, scale_mode_low_bit});
    if (arith_saturation_mode) begin
      store_scale = SCALE_NONE; // see RULE12
    end
  end

  function automatic logic [DATA_W-1:0] scale_val(input logic [DATA_W-1:0] v,
                                                  input scale_mode_type s);
    logic [DATA_W-1:0] r;
    r = v;
    unique case (s)
      SCALE_DOWN: r = {v[39], v[39:1]};
      SCALE_UP:   r = {v[38:0], 1'b0};
      default:    r = v;
    endcase
    return r;
  endfunction : scale_val

  assign src0_scaled = scale_val(src0_val, store_scale);
  assign src1_scaled = scale_val(src1_val, store_scale);

  function automatic logic [15:0] lim_word(input logic [DATA_W-1:0] v, input logic tag,
                                           input logic [15:0] d);
    return tag ? (v[39] ? WORD_NEG_MAX : WORD_POS_MAX) : d; // see RULE2 see RULE11 see RULE16
  endfunction : lim_word

  function automatic logic [31:0] lim_long(input logic [DATA_W-1:0] v, input logic tag,
                                           input logic [31:0] d);
    return tag ? (v[39] ? LONG_NEG_MAX : LONG_POS_MAX) : d; // see RULE11 see RULE17
  endfunction : lim_long

  // Each bus carries two 16-bit limiter slots in bits 31:0; the two combine for one long.
  always_comb begin
    bus_a_nxt = '0;
    bus_b_nxt = '0;
    unique case (store_req.kind)
      ST_PLAIN: begin
        bus_a_nxt[31:0] = src0_val[31:0]; // see RULE1 see RULE18
      end
      ST_FRAC: begin
        bus_a_nxt[15:0] = lim_word(src0_val, src0_tag, src0_scaled[31:16]); // see RULE1
      end
      ST_TWO_F: begin
        bus_a_nxt[15:0]  = lim_word(src0_val, src0_tag, src0_scaled[31:16]);
        bus_a_nxt[31:16] = lim_word(src1_val, src1_tag, src1_scaled[31:16]); // see RULE10
      end
      ST_FOUR_F: begin
        bus_a_nxt[15:0]  = lim_word(src0_val, src0_tag, src0_scaled[31:16]);
        bus_a_nxt[31:16] = lim_word(src1_val, src1_tag, src1_scaled[31:16]);
        bus_b_nxt[15:0]  = lim_word(src0_val, src0_tag, src0_scaled[15:0]);
        bus_b_nxt[31:16] = lim_word(src1_val, src1_tag, src1_scaled[15:0]); // see RULE10
      end
      ST_LONG: begin
        bus_a_nxt[31:0] = lim_long(src0_val, src0_tag, src0_scaled[31:0]); // see RULE10
        bus_b_nxt[31:0] = lim_long(src1_val, src1_tag, src1_scaled[31:0]);
      end
      default: begin
        bus_a_nxt = '0;
        bus_b_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_bus_a <= '0;
      data_bus_b <= '0;
      bus_valid  <= 1'b0;
    end else begin
      data_bus_a <= bus_a_nxt;
      data_bus_b <= bus_b_nxt;
      bus_valid  <= store_req.kind != ST_NONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_read_value <= '0;
      limit_tag_bit  <= 1'b0;
    end else begin
      reg_read_value <= src0_val; // see RULE3
      limit_tag_bit  <= src0_tag;
    end
  end

  // Rounding boundary position.
  always_comb begin
    rnd_nxt = RND_POS_NONE;
    if (!arith_saturation_mode) begin
      unique case (scale_eff)
        SCALE_DOWN: rnd_nxt = RND_POS_DOWN; // see RULE14
        SCALE_UP:   rnd_nxt = RND_POS_UP;
        default:    rnd_nxt = RND_POS_NONE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      round_position <= RND_POS_NONE;
    end else begin
      round_position <= rnd_nxt;
    end
  end

  // APB slave: zero wait states, error on unmapped offsets.
  assign apb_access = psel && penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_status_register <= STATUS_RESET;
    end else if (apb_access && pwrite && paddr[11:2] == {7'h00, APB_OFS_STATUS}) begin
      core_status_register <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_count_r <= '0;
    end else if (store_req.kind inside {ST_FRAC, ST_TWO_F, ST_FOUR_F, ST_LONG}) begin
      store_count_r <= store_count_r + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable) begin
        if (paddr[11:5] != 7'h00 || paddr[4:2] > APB_OFS_RNDPOS) begin
          pslverr <= 1'b1;
        end else if (!pwrite) begin
          unique case (paddr[4:2])
            APB_OFS_STATUS: prdata <= core_status_register;
            APB_OFS_TAGS:   prdata <= 32'(limit_tags_r);
            APB_OFS_STORES: prdata <= {16'h0000, store_count_r};
            APB_OFS_RNDPOS: prdata <= {27'h0000000, round_position};
            default:        prdata <= '0;
          endcase
        end
      end
    end
  end
endmodule : store_limiter_tag_logic

// file: bench/store_limiter_checker_assertions.sv
// Checker of the bus handshake and the store limiter outputs.
`timescale 1ns/1ps
module store_limiter_checker
  import store_limiter_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire store_req_type     store_req,
  input wire logic [BUS_W-1:0]  data_bus_a,
  input wire logic              bus_valid,
  input wire logic [DATA_W-1:0] reg_read_value,
  input wire logic              limit_tag_bit
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_frac_tag;
    store_req.kind == ST_FRAC ##1 limit_tag_bit;
  endsequence
  sequence s_long_tag;
    store_req.kind == ST_LONG ##1 limit_tag_bit;
  endsequence
  property p_answer; psel && !penable |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_valid; store_req.kind != ST_NONE |=> bus_valid; endproperty
  property p_idle; store_req.kind == ST_NONE |=> !bus_valid; endproperty
  property p_frac;
    s_frac_tag |-> data_bus_a[15:0] == (reg_read_value[39] ? WORD_NEG_MAX : WORD_POS_MAX);
  endproperty
  property p_long;
    s_long_tag |-> data_bus_a[31:0] == (reg_read_value[39] ? LONG_NEG_MAX : LONG_POS_MAX);
  endproperty
  property p_plain;
    store_req.kind == ST_PLAIN |=> data_bus_a[31:0] == reg_read_value[31:0];
  endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("error without ready");
  a_valid: assert property (p_valid) else $error("store without valid");
  a_idle: assert property (p_idle) else $error("valid without store");
  a_frac: assert property (p_frac) else $error("word not saturated");
  a_long: assert property (p_long) else $error("long not saturated");
  a_plain: assert property (p_plain) else $error("plain move altered");
endmodule : store_limiter_checker

bind store_limiter_tag_logic store_limiter_checker u_store_limiter_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .store_req(store_req), .data_bus_a(data_bus_a),
  .bus_valid(bus_valid), .reg_read_value(reg_read_value), .limit_tag_bit(limit_tag_bit));

// file: bench/data_mem_model.sv
// Data memory model that keeps the last store seen on both buses.
`timescale 1ns/1ps
module data_mem_model
  import store_limiter_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             bus_valid,
  input  wire logic [BUS_W-1:0] data_bus_a,
  input  wire logic [BUS_W-1:0] data_bus_b,
  output logic      [BUS_W-1:0] mem_a,
  output logic      [BUS_W-1:0] mem_b
);
  always_ff @(posedge pclk) begin
    if (bus_valid) begin
      mem_a <= data_bus_a;
      mem_b <= data_bus_b;
    end
  end
endmodule : data_mem_model

// file: bench/tb.sv
// Self-checking bench of the limit tag and store limiter block.
`timescale 1ns/1ps
module tb;
  import store_limiter_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err, tag;
  logic              bus_valid, limit_tag_bit;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [4:0]        round_position;
  logic [BUS_W-1:0]  data_bus_a, data_bus_b, mem_a, mem_b;
  logic [DATA_W-1:0] reg_read_value, rv;
  reg_write_type     reg_write;
  store_req_type     store_req;
  int                failures, compares, cycles;

  store_limiter_tag_logic u_store_limiter_tag_logic (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reg_write, .store_req,
    .data_bus_a, .data_bus_b, .bus_valid, .reg_read_value, .limit_tag_bit, .round_position);
  data_mem_model u_data_mem_model (.pclk, .bus_valid, .data_bus_a, .data_bus_b, .mem_a, .mem_b);

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Look at ready between edges so the value seen is the one the next edge samples.
    @(negedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 20) failures++;
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wreg(input logic [3:0] r, input logic [39:0] v, input tag_class_type c,
                      input logic rs = 1'b0);
    @(posedge pclk);
    reg_write <= '{1'b1, r, v, c, rs, rs};
    @(posedge pclk);
    reg_write <= '0;
  endtask : wreg

  task automatic st(input store_kind_type k, input logic [3:0] s0, input logic [3:0] s1);
    @(posedge pclk);
    store_req <= '{k, s0, s1};
    @(posedge pclk);
    store_req <= '{ST_NONE, 4'h0, 4'h0};
    #1;
    tag = limit_tag_bit;
    rv = reg_read_value;
    @(posedge pclk);
    #1;
  endtask : st

  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  initial begin
    pclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles > 5000) begin
      failures++;
      test_done();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    reg_write = '0;
    store_req = '0;
    failures = 0;
    compares = 0;
    cycles = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("round", round_position, RND_POS_NONE);
    apb(1'b0, 12'h000, 32'h0);
    chk("status", rd, STATUS_RESET);
    $display("test reset done");
    wreg(0, 40'h01_7fff_0000, TAG_CALC);
    st(ST_FRAC, 0, 0);
    chk("tag", tag, 1'b1);
    chk("word", mem_a[15:0], WORD_POS_MAX);
    chk("reg", rv, 40'h01_7fff_0000);
    st(ST_PLAIN, 0, 0);
    chk("plain", mem_a[31:0], 32'h7fff_0000);
    wreg(1, 40'hfe_8000_1234, TAG_CALC);
    st(ST_LONG, 1, 0);
    chk("long a", mem_a[31:0], LONG_NEG_MAX);
    chk("long b", mem_b[31:0], LONG_POS_MAX);
    wreg(2, 40'h00_1234_5678, TAG_CALC);
    wreg(3, 40'h01_2345_0000, TAG_CLEAR);
    st(ST_TWO_F, 2, 3);
    chk("tag", tag, 1'b0);
    chk("two", mem_a[31:0], 32'h2345_1234);
    st(ST_FOUR_F, 2, 0);
    chk("four a", mem_a[31:0], 32'h7fff_1234);
    chk("four b", mem_b[31:0], 32'h7fff_5678);
    $display("test limit done");
    apb(1'b1, 12'h000, 32'h14);
    wreg(4, 40'h01_7fff_0000, TAG_CALC);
    st(ST_FRAC, 4, 0);
    chk("tag", tag, 1'b0);
    chk("round", round_position, RND_POS_NONE);
    wreg(5, 40'h00_8000_0000, TAG_SPECIAL);
    st(ST_FRAC, 5, 0);
    chk("tag", tag, 1'b1);
    chk("word", mem_a[15:0], WORD_POS_MAX);
    wreg(6, 40'h00_2000_0000, TAG_CALC);
    st(ST_FRAC, 6, 0);
    chk("word", mem_a[15:0], 16'h2000);
    $display("test saturation done");
    apb(1'b1, 12'h000, 32'h10);
    wreg(6, 40'h00_8000_0000, TAG_CALC);
    st(ST_FRAC, 6, 0);
    chk("tag", tag, 1'b0);
    chk("word", mem_a[15:0], 16'h4000);
    chk("round", round_position, RND_POS_DOWN);
    apb(1'b1, 12'h000, 32'h20);
    wreg(7, 40'h00_4000_0000, TAG_CALC);
    st(ST_FRAC, 7, 0);
    chk("tag", tag, 1'b1);
    chk("word", mem_a[15:0], WORD_POS_MAX);
    $display("test scaling done");
    wreg(8, 40'h00_0000_0000, TAG_CLEAR, 1'b1);
    st(ST_FRAC, 8, 0);
    chk("tag", tag, 1'b1);
    apb(1'b0, 12'h00c, 32'h0);
    chk("rndpos", rd[4:0], RND_POS_UP);
    apb(1'b0, 12'h010, 32'h0);
    chk("err", err, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    chk("status", rd, 32'h20);
    apb(1'b0, 12'h004, 32'h0);
    chk("tags", rd, 32'h000001a3);
    apb(1'b0, 12'h008, 32'h0);
    chk("stores", rd, 32'h0000000a);
    chk("err", err, 1'b0);
    $display("test restore done");
    test_done();
  end
endmodule : tb
